// *** src/rram_pkg.sv ***
/*
 * Package for the radio register access layer: register offsets, reset values,
 * per-bit access masks and recommended init values.
 * Assumes an 8-bit register port with byte offsets relative to the bank base.
 */
package rram_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;

    // Byte offsets within the bank (relative to base)
    localparam logic [7:0] OFF_SYNTH_CAL_ONE   = 8'h2E;
    localparam logic [7:0] OFF_GAIN_TARGET     = 8'h32;
    localparam logic [7:0] OFF_GAIN_OVERRIDE   = 8'h33;
    localparam logic [7:0] OFF_EVENT_FLAGS     = 8'h40;
    localparam logic [7:0] OFF_ENABLE_FLAGS    = 8'h41;
    localparam logic [7:0] OFF_TX_ANTIALIAS    = 8'h7A;

    // Reset values (neutral defaults)
    localparam logic [7:0] RST_SYNTH_CAL_ONE   = 8'h00;
    localparam logic [7:0] RST_GAIN_TARGET     = 8'h00;
    localparam logic [7:0] RST_GAIN_OVERRIDE   = 8'h00;
    localparam logic [7:0] RST_TX_ANTIALIAS    = 8'h00;
    localparam logic [7:0] RST_EVENT_FLAGS     = 8'h00;
    localparam logic [7:0] RST_ENABLE_FLAGS    = 8'h00;

    // Recommended startup values written by software
    localparam logic [7:0] INIT_GAIN_TARGET    = 8'h15;
    localparam logic [7:0] INIT_TX_ANTIALIAS   = 8'h09;
    localparam logic [7:0] INIT_SYNTH_CAL_ONE  = 8'h00;

    // gain_override_control layout: [7:6] read constant, [5] override enable, [4:0] gain value
    localparam int GOV_EN_BIT = 5;
    localparam int GOV_VAL_W  = 5;
    localparam logic [7:0] GOV_RCONST_LOW_MASK  = 8'h80;
    localparam logic [7:0] GOV_RCONST_HIGH_MASK = 8'h40;

    // synth_calibration_one: [7] read constant low, rest plain
    localparam logic [7:0] SCAL_RCONST_LOW_MASK = 8'h80;

endpackage

// *** src/rram_bit_cell.sv ***
/*
 * One bit of configurable access kind: plain, write-one-only or write-zero-only.
 * Assumes write strobe and data from the same clock domain.
 */
`timescale 1ns/1ps
module rram_bit_cell #(
    parameter logic [1:0] KIND     = 2'h0,
    parameter logic       RST_VAL  = 1'b0
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic nrst,
    // Write side
    input  wire logic wrEn,
    input  wire logic wrBit,
    // Hardware set, wins over software clear
    input  wire logic hwSet,
    // State
    output logic      bitQ
);
    typedef struct packed {
        logic v;
    } rram_cell_t;

    rram_cell_t st_q;
    rram_cell_t st_d;

    always_comb begin
        st_d = st_q;
        if (wrEn) begin
            case (KIND)
                2'h1: begin
                    if (wrBit) st_d.v = 1'b1;
                end
                2'h2: begin
                    if (!wrBit) st_d.v = 1'b0;
                end
                default: st_d.v = wrBit;
            endcase
        end
        if (hwSet) begin
            st_d.v = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= '{v: RST_VAL};
        end else begin
            st_q <= st_d;
        end
    end

    assign bitQ = st_q.v;
endmodule

// *** src/rram_regs.sv ***
/*
 * Register access layer of the radio core configuration bank.
 * Holds plain, write-one-only, write-zero-only, read-constant and
 * module-seen readback bits; exposes the values the radio datapath uses.
 * Bank contents: gain target, gain override, transmit anti-alias filter,
 * synthesiser calibration one, event flags (cleared by writing zero) and
 * enable flags (set by writing one, cleared only by reset).
 * Read-constant bits are forced on the read path and are never stored.
 * Assumes a single-cycle register port on clk, data one cycle after read.
 * Assumes autoGain and hwEvents come from logic on clk, so no synchronisers.
 * A hardware event and a software clear in one cycle leave the flag set.
 */
// Chosen here: strobed register access and the register offsets.
// Behaviour
// - Write-one-only bits change only on a written one; written zero ignored.
// - Write-zero-only bits change only on a written zero; written one ignored.
// - Module-seen bits read back the value in use, not the stored content.
// - Value in use is the automatic value or software override, as selected.
`timescale 1ns/1ps
module rram_regs (
    // Clock and reset
    input  wire logic                       clk,
    input  wire logic                       nrst,
    // Register port
    input  wire logic [rram_pkg::ADDR_W-1:0] regAddr,
    input  wire logic [rram_pkg::DATA_W-1:0] regWdata,
    input  wire logic                       regWr,
    input  wire logic                       regRd,
    output logic      [rram_pkg::DATA_W-1:0] regRdata,
    // Automatic control from calibration / gain loop
    input  wire logic [rram_pkg::GOV_VAL_W-1:0] autoGain,
    input  wire logic [7:0]                 hwEvents,
    // Values used by the radio datapath
    output logic      [rram_pkg::GOV_VAL_W-1:0] gainInUse,
    output logic      [7:0]                 gainTarget,
    output logic      [7:0]                 txAntialiasCfg,
    output logic      [7:0]                 synthCalOne,
    output logic      [7:0]                 enableFlags,
    output logic      [7:0]                 eventFlags
);
    import rram_pkg::*;

    typedef struct packed {
        logic [7:0] gainTarget;
        logic [7:0] gainOverride;
        logic [7:0] txAntialias;
        logic [7:0] synthCal;
        logic [7:0] rdata;
    } rram_regs_t;

    rram_regs_t st_q;
    rram_regs_t st_d;

    // Access kinds understood by the bit cell
    localparam logic [1:0] KIND_WRITE_ONE_ONLY  = 2'h1;
    localparam logic [1:0] KIND_WRITE_ZERO_ONLY = 2'h2;

    // Flag bits live in the access cells
    logic [7:0]           evQ;
    logic [7:0]           enQ;
    logic                 wrEv;
    logic                 wrEn;
    logic [GOV_VAL_W-1:0] gainSel;

    // One hit per mapped register; unmapped offsets hit nothing
    logic                 hitGainTarget;
    logic                 hitGainOverride;
    logic                 hitTxAntialias;
    logic                 hitSynthCal;
    logic                 hitEvent;
    logic                 hitEnable;

    assign hitGainTarget   = (regAddr == OFF_GAIN_TARGET);
    assign hitGainOverride = (regAddr == OFF_GAIN_OVERRIDE);
    assign hitTxAntialias  = (regAddr == OFF_TX_ANTIALIAS);
    assign hitSynthCal     = (regAddr == OFF_SYNTH_CAL_ONE);
    assign hitEvent        = (regAddr == OFF_EVENT_FLAGS);
    assign hitEnable       = (regAddr == OFF_ENABLE_FLAGS);

    // Write strobes per register
    logic                 wrGainTarget;
    logic                 wrGainOverride;
    logic                 wrTxAntialias;
    logic                 wrSynthCal;

    assign wrGainTarget   = regWr && hitGainTarget;
    assign wrGainOverride = regWr && hitGainOverride;
    assign wrTxAntialias  = regWr && hitTxAntialias;
    assign wrSynthCal     = regWr && hitSynthCal;
    assign wrEv           = regWr && hitEvent;
    assign wrEn           = regWr && hitEnable;

    // Read-constant bits hold no state, so writes to them are dropped
    logic [7:0]           govStoreMask;
    logic [7:0]           scalStoreMask;

    assign govStoreMask  = ~(GOV_RCONST_LOW_MASK | GOV_RCONST_HIGH_MASK);
    assign scalStoreMask = ~SCAL_RCONST_LOW_MASK;

    // Readback words as software sees them
    logic [7:0]           rdGainTarget;
    logic [7:0]           rdGainOverride;
    logic [7:0]           rdTxAntialias;
    logic [7:0]           rdSynthCal;
    logic [7:0]           rdEvent;
    logic [7:0]           rdEnable;
    logic [7:0]           rdWord;

    genvar i;
    generate
        // Event flags: software clears by writing zero; hardware set wins
        for (i = 0; i < 8; i++) begin : g_event
            rram_bit_cell #(
                .KIND    (KIND_WRITE_ZERO_ONLY),
                .RST_VAL (RST_EVENT_FLAGS[i])
            ) u_ev (
                .clk   (clk),
                .nrst  (nrst),
                .wrEn  (wrEv),
                .wrBit (regWdata[i]),
                .hwSet (hwEvents[i]),
                .bitQ  (evQ[i])
            );
        end

        // Enable flags: software may only set them; reset is the only clear
        for (i = 0; i < 8; i++) begin : g_enable
            rram_bit_cell #(
                .KIND    (KIND_WRITE_ONE_ONLY),
                .RST_VAL (RST_ENABLE_FLAGS[i])
            ) u_en (
                .clk   (clk),
                .nrst  (nrst),
                .wrEn  (wrEn),
                .wrBit (regWdata[i]),
                .hwSet (1'b0),
                .bitQ  (enQ[i])
            );
        end
    endgenerate

    // Override enable picks the stored value, else the automatic one
    assign gainSel = st_q.gainOverride[GOV_EN_BIT] ? st_q.gainOverride[GOV_VAL_W-1:0]
                                                    : autoGain;

    // Low field reads what the gain loop uses, not the stored byte
    assign rdGainOverride = ({st_q.gainOverride[7:GOV_EN_BIT], gainSel} & ~GOV_RCONST_LOW_MASK)
                          | GOV_RCONST_HIGH_MASK;
    assign rdGainTarget   = st_q.gainTarget;
    assign rdTxAntialias  = st_q.txAntialias;
    assign rdSynthCal     = st_q.synthCal & ~SCAL_RCONST_LOW_MASK;
    assign rdEvent        = evQ;
    assign rdEnable       = enQ;

    // Read mux; unmapped offsets read zero
    always_comb begin
        rdWord = 8'h00;
        if (hitGainTarget) begin
            rdWord = rdGainTarget;
        end
        if (hitGainOverride) begin
            rdWord = rdGainOverride;
        end
        if (hitTxAntialias) begin
            rdWord = rdTxAntialias;
        end
        if (hitSynthCal) begin
            rdWord = rdSynthCal;
        end
        if (hitEvent) begin
            rdWord = rdEvent;
        end
        if (hitEnable) begin
            rdWord = rdEnable;
        end
    end

    always_comb begin
        st_d = st_q;
        // Plain registers take the whole byte
        if (wrGainTarget) begin
            st_d.gainTarget = regWdata;
        end
        if (wrTxAntialias) begin
            st_d.txAntialias = regWdata;
        end
        // Override bits 7:6 read as constants and are not kept
        if (wrGainOverride) begin
            st_d.gainOverride = regWdata & govStoreMask;
        end
        // Calibration bit 7 reads as a constant and is not kept
        if (wrSynthCal) begin
            st_d.synthCal = regWdata & scalStoreMask;
        end
        // Read data stands only in the cycle after the strobe, zero otherwise
        st_d.rdata = 8'h00;
        if (regRd) begin
            st_d.rdata = rdWord;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st_q <= '{gainTarget:   RST_GAIN_TARGET,
                      gainOverride: RST_GAIN_OVERRIDE,
                      txAntialias:  RST_TX_ANTIALIAS,
                      synthCal:     RST_SYNTH_CAL_ONE,
                      rdata:        8'h00};
        end else begin
            st_q <= st_d;
        end
    end

    // Settings are held across receive and transmit; nothing here clears them
    assign regRdata       = st_q.rdata;
    assign gainInUse      = gainSel;
    assign gainTarget     = st_q.gainTarget;
    assign txAntialiasCfg = st_q.txAntialias;
    assign synthCalOne    = st_q.synthCal & ~SCAL_RCONST_LOW_MASK;
    assign enableFlags    = enQ;
    assign eventFlags     = evQ;
endmodule

// *** tb/rram_regs_assertions.sv ***
/* Port checker for rram_regs access kinds.
   Assumes one clock, async active-low reset, read data one cycle after the strobe. */
`timescale 1ns/1ps
module rram_regs_chk (
    // Watched ports
    input wire logic       clk,
    input wire logic       nrst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic       regWr,
    input wire logic       regRd,
    input wire logic [7:0] regRdata,
    input wire logic [7:0] hwEvents,
    input wire logic [4:0] autoGain,
    input wire logic [4:0] gainInUse,
    input wire logic [7:0] gainTarget,
    input wire logic [7:0] synthCalOne,
    input wire logic [7:0] enableFlags,
    input wire logic [7:0] eventFlags
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    a_wone_keep: assert property ((~enableFlags & $past(enableFlags)) == 8'h00)
        else $error("enable flag cleared");
    a_wone_set: assert property (regWr && regAddr == 8'h41 |=>
        (enableFlags & $past(regWdata)) == $past(regWdata)) else $error("enable flag not set");
    a_wzero_hold: assert property ((eventFlags & ~$past(eventFlags) & ~$past(hwEvents)) == 8'h00)
        else $error("event flag set by software");
    a_wzero_clr: assert property (regWr && regAddr == 8'h40 && hwEvents == 8'h00 |=>
        (eventFlags & ~$past(regWdata)) == 8'h00) else $error("event flag not cleared");
    a_mseen_read: assert property (regRd && regAddr == 8'h33 |=>
        regRdata[4:0] == $past(gainInUse)) else $error("readback not value in use");
    a_mseen_auto: assert property (regRd && regAddr == 8'h33 |=>
        regRdata[5] || regRdata[4:0] == $past(autoGain)) else $error("readback not automatic value");
    a_rconst_read: assert property (regRd && regAddr == 8'h33 |=> regRdata[7:6] == 2'h1)
        else $error("read constant wrong");
    a_synth_low: assert property (regRd && regAddr == 8'h2E |=> !regRdata[7] && !synthCalOne[7])
        else $error("synth bit7 not zero");
    a_target_copy: assert property (regWr && regAddr == 8'h32 |=> gainTarget == $past(regWdata))
        else $error("gain target not written");
    c_wone: cover property (regWr && regAddr == 8'h41);
    c_wzero: cover property (regWr && regAddr == 8'h40);
    c_mseen: cover property (regRd && regAddr == 8'h33);
endmodule

bind rram_regs rram_regs_chk i_chk (.clk, .nrst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
    .hwEvents, .autoGain, .gainInUse, .gainTarget, .synthCalOne, .enableFlags, .eventFlags);

// *** tb/testbench.sv ***
/* Self-checking bench for rram_regs.
   Assumes the port checker is bound from its own file. */
`timescale 1ns/1ps
module testbench;
    import rram_pkg::*;
    logic       clk = 1'b0;
    logic       nrst = 1'b0;
    logic [7:0] regAddr = 8'h00, regWdata = 8'h00, hwEvents = 8'h00;
    logic       regWr = 1'b0, regRd = 1'b0;
    logic [4:0] autoGain = 5'h00, gainInUse;
    logic [7:0] regRdata, gainTarget, txAntialiasCfg, synthCalOne, enableFlags, eventFlags;
    int         bad_count = 0;
    int         total_checks = 0;

    rram_regs i_dut (.clk, .nrst, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .autoGain, .hwEvents,
        .gainInUse, .gainTarget, .txAntialiasCfg, .synthCalOne, .enableFlags, .eventFlags);

    always #5 clk = ~clk;

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
        #1;
    endtask

    // Data valid only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1 chk(regRdata, exp);
    endtask

    task automatic t_init;
        wr(OFF_GAIN_TARGET, INIT_GAIN_TARGET);
        chk(gainTarget, 8'h15);
        wr(OFF_TX_ANTIALIAS, INIT_TX_ANTIALIAS);
        chk(txAntialiasCfg, 8'h09);
        wr(OFF_SYNTH_CAL_ONE, 8'hFF);
        rd(OFF_SYNTH_CAL_ONE, 8'h7F);
        wr(OFF_SYNTH_CAL_ONE, INIT_SYNTH_CAL_ONE);
        chk(synthCalOne, 8'h00);
        rd(OFF_GAIN_TARGET, 8'h15);
        rd(8'h00, 8'h00);
    endtask

    task automatic t_wone;
        wr(OFF_ENABLE_FLAGS, 8'h05);
        chk(enableFlags, 8'h05);
        wr(OFF_ENABLE_FLAGS, 8'h00);
        chk(enableFlags, 8'h05);
        wr(OFF_ENABLE_FLAGS, 8'h50);
        chk(enableFlags, 8'h55);
    endtask

    task automatic t_wzero;
        @(posedge clk);
        hwEvents <= 8'h0F;
        @(posedge clk);
        hwEvents <= 8'h00;
        #1 chk(eventFlags, 8'h0F);
        wr(OFF_EVENT_FLAGS, 8'hFF);
        chk(eventFlags, 8'h0F);
        wr(OFF_EVENT_FLAGS, 8'hFA);
        chk(eventFlags, 8'h0A);
    endtask

    task automatic t_mseen;
        @(posedge clk);
        autoGain <= 5'h0A;
        wr(OFF_GAIN_OVERRIDE, 8'h13);
        chk({3'h0, gainInUse}, 8'h0A);
        rd(OFF_GAIN_OVERRIDE, 8'h4A);
        wr(OFF_GAIN_OVERRIDE, 8'hB3);
        chk({3'h0, gainInUse}, 8'h13);
        @(posedge clk);
        autoGain <= 5'h1C;
        rd(OFF_GAIN_OVERRIDE, 8'h73);
        chk({3'h0, gainInUse}, 8'h13);
        wr(OFF_GAIN_OVERRIDE, 8'h00);
        chk({3'h0, gainInUse}, 8'h1C);
        rd(OFF_GAIN_OVERRIDE, 8'h5C);
    endtask

    task automatic report_and_stop;
        if (bad_count == 0 && total_checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        t_init;
        t_wone;
        t_wzero;
        t_mseen;
        report_and_stop;
    end

    initial begin
        #20us;
        bad_count++;
        report_and_stop;
    end
endmodule
